// file: rtl/rse_cfg.svh
/*
  Constants of the receive event logic: register offsets, field positions,
  reset values and sizes.
  Assumes it is included by bare name by the package and the port checker.
*/
`ifndef RSE_CFG_SVH
`define RSE_CFG_SVH

// register port
`define RSE_ADDR_W        6
`define RSE_DATA_W        8
`define RSE_OFF_CTRL      6'h06
`define RSE_OFF_EN        6'h07
`define RSE_OFF_STAT      6'h08
`define RSE_OFF_DATA_A    6'h09
`define RSE_OFF_VALID_A   6'h0A
`define RSE_OFF_DATA_B    6'h0B
`define RSE_OFF_VALID_B   6'h0C

// reset values
`define RSE_RST_BYTE      8'h00
`define RSE_RST_GAP       3'h0

// deserialiser control fields
`define RSE_GAP_W         3
`define RSE_GAP_MSB       2
`define RSE_GAP_LSB       0

// status bit positions
`define RSE_ST_VALID_B    7
`define RSE_ST_FLOW_B     6
`define RSE_ST_EOF_B      5
`define RSE_ST_FULL_B     4
`define RSE_ST_VALID_A    3
`define RSE_ST_FLOW_A     2
`define RSE_ST_EOF_A      1
`define RSE_ST_FULL_A     0

// enable bit positions
`define RSE_EN_UNF_B      7
`define RSE_EN_OVF_B      6
`define RSE_EN_EOF_B      5
`define RSE_EN_FULL_B     4
`define RSE_EN_UNF_A      3
`define RSE_EN_OVF_A      2
`define RSE_EN_EOF_A      1
`define RSE_EN_FULL_A     0

// sizes
`define RSE_BYTE_W        8
`define RSE_FIFO_DEPTH    16
`define RSE_FIFO_WIDTH    4

`endif

// file: rtl/rse_chan.sv
/*
  One receive channel: frame tracking, end-of-frame detection, byte assembly
  and the holding register with its overflow and underflow events.
  Assumes one bit time per bit_stb_i pulse and a host read strobe on hold_rd_i.
*/
`timescale 1ns/100ps
`default_nettype none

module rse_chan
  import rse_pkg::*;
#(
  parameter int BYTE_W = `RSE_BYTE_W,
  parameter int GAP_W  = `RSE_GAP_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              rx_en_i,
  input  wire logic [GAP_W-1:0]  gap_len_i,
  input  wire logic              bit_stb_i,
  input  wire logic              bit_data_i,
  input  wire logic              bit_ok_i,
  input  wire logic              hold_rd_i,
  output logic      [BYTE_W-1:0] hold_data_o,
  output logic      [BYTE_W-1:0] hold_mask_o,
  output logic                   load_o,
  output logic                   all_valid_o,
  output logic                   ovf_o,
  output logic                   unf_o,
  output logic                   eof_o
);

  localparam int IDX_W = $clog2(BYTE_W);

  generate
    if (BYTE_W < 2 || (1 << IDX_W) != BYTE_W || GAP_W < 1) begin : g_bad
      $error("rse_chan: BYTE_W must be a power of two >= 2");
    end
  endgenerate

  rse_rx_state_t     state;
  logic [IDX_W-1:0]  idx;
  logic [BYTE_W-1:0] shift_data;
  logic [BYTE_W-1:0] shift_mask;
  logic [GAP_W-1:0]  gap_cnt;
  logic              hold_full;

  // framing decode: the bit that makes the gap exceed the length ends it
  wire in_frame  = (state == RSE_FRAME);
  wire is_eof    = bit_stb_i & in_frame & ~bit_ok_i & (gap_cnt == gap_len_i);
  wire frame_bit = bit_stb_i & (bit_ok_i | (in_frame & ~is_eof));
  wire byte_done = frame_bit & (idx == IDX_W'(BYTE_W - 1));
  wire partial   = is_eof & (idx != '0);
  wire do_load   = byte_done | partial;

  // merge the current bit into the byte under assembly, bit 0 first on air
  wire [BYTE_W-1:0] bit_sel     = {{(BYTE_W-1){1'b0}}, 1'b1} << idx;
  wire [BYTE_W-1:0] merged_data = (shift_data & ~bit_sel) | (bit_data_i ? bit_sel : '0);
  wire [BYTE_W-1:0] merged_mask = (shift_mask & ~bit_sel) | (bit_ok_i ? bit_sel : '0);
  wire [BYTE_W-1:0] load_data   = byte_done ? merged_data : shift_data;
  wire [BYTE_W-1:0] load_mask   = byte_done ? merged_mask : shift_mask;

  // framing state, gap counter and shift registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= RSE_IDLE;
      idx        <= '0;
      shift_data <= '0;
      shift_mask <= '0;
      gap_cnt    <= '0;
    end else if (ce_i) begin
      if (!rx_en_i || is_eof) begin
        state      <= RSE_IDLE;
        idx        <= '0;
        shift_data <= '0;
        shift_mask <= '0;
        gap_cnt    <= '0;
      end else if (frame_bit) begin
        state      <= RSE_FRAME;
        idx        <= byte_done ? '0 : idx + IDX_W'(1);
        shift_data <= byte_done ? '0 : merged_data;
        shift_mask <= byte_done ? '0 : merged_mask;
        gap_cnt    <= bit_ok_i ? '0 : gap_cnt + GAP_W'(1);
      end
    end
  end

  // holding register and its event pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_data_o <= '0;
      hold_mask_o <= '0;
      hold_full   <= 1'b0;
      load_o      <= 1'b0;
      all_valid_o <= 1'b0;
      ovf_o       <= 1'b0;
      unf_o       <= 1'b0;
      eof_o       <= 1'b0;
    end else if (ce_i) begin
      load_o <= rx_en_i & do_load;
      ovf_o  <= rx_en_i & do_load & hold_full & ~hold_rd_i;
      unf_o  <= rx_en_i & hold_rd_i & ~hold_full;
      eof_o  <= rx_en_i & is_eof;
      if (!rx_en_i) begin
        hold_data_o <= '0;
        hold_mask_o <= '0;
        hold_full   <= 1'b0;
        all_valid_o <= 1'b0;
      end else if (do_load) begin
        hold_data_o <= load_data;
        hold_mask_o <= load_mask;
        hold_full   <= 1'b1;
        all_valid_o <= &load_mask;
      end else if (hold_rd_i) begin
        hold_full <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/rse_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock, a synchronous active-low reset copy and a clock enable.
*/
`timescale 1ns/100ps
`default_nettype none

module rse_fifo
  import rse_pkg::*;
#(
  parameter int WIDTH = `RSE_FIFO_WIDTH,
  parameter int DEPTH = `RSE_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             s_valid_i,
  input  wire logic [WIDTH-1:0] s_data_i,
  output var  logic             s_ready_o,
  output var  logic             m_valid_o,
  output logic      [WIDTH-1:0] m_data_o,
  input  wire logic             m_ready_i
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  // pointers wrap naturally only for a power-of-two depth
  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad
      $error("rse_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  wire              push = s_valid_i & s_ready_o;
  wire              pop  = m_valid_o & m_ready_i;
  wire  [CNT_W-1:0] next_count = count + CNT_W'(push) - CNT_W'(pop);

  assign m_data_o = mem[rd_ptr];

  // pointers, occupancy and the registered full/empty flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      s_ready_o <= 1'b0;
      m_valid_o <= 1'b0;
    end else if (ce_i) begin
      wr_ptr    <= wr_ptr + PTR_W'(push);
      rd_ptr    <= rd_ptr + PTR_W'(pop);
      count     <= next_count;
      s_ready_o <= (next_count != CNT_W'(DEPTH));
      m_valid_o <= (next_count != '0);
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= s_data_i;
    end
  end

endmodule

`default_nettype wire

// file: rtl/rse_pkg.sv
/*
  Types shared by the receive event logic.
  Assumes rse_cfg.svh is on the include path.
*/
`include "rse_cfg.svh"

package rse_pkg;

  // receiver framing state, one-hot
  typedef enum logic [1:0] {
    RSE_IDLE  = 2'b01,
    RSE_FRAME = 2'b10
  } rse_rx_state_t;

  typedef logic [`RSE_DATA_W-1:0] rse_byte_t;

endpackage

// file: rtl/rse_top.sv
/*
  Receive event logic of the byte deserialiser: control, enable and status
  registers, two receive channels and the bit FIFO in front of them.
  Assumes register accesses arrive already decoded from the serial host
  port as one-cycle read and write strobes with an address, and that the
  demodulator presents one bit time per accepted FIFO entry.
*/
// Notes on behaviour
// - enable bit 3 gates channel A underflow
// - enable bit 2 gates channel A overflow
// - enable bit 1 gates channel A end-of-frame
// - end of frame after valid bit, gap exceeded
// - zero gap ends on first invalid bit
// - status read clears pending end-of-frame
// - enable bit 0 gates channel A full
// - full on byte complete or mid-byte end of frame
// - status at 0x08, reset zero, B high
// - bit 7 shows channel B byte all valid
// - all-valid bit never raises the interrupt
// - bit 6 set on B overflow or underflow
// - flow violation pending until status read
// - bit 5 channel B end-of-frame, read clears
// - status polls without enables, zero outside receive
// - gap length from control bits 2..0
`timescale 1ns/100ps
`default_nettype none

module rse_top
  import rse_pkg::*;
#(
  parameter int FIFO_DEPTH = `RSE_FIFO_DEPTH
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   ce_i,
  input  wire logic                   rx_en_i,
  input  wire logic                   bit_valid_i,
  input  wire logic                   bit_a_data_i,
  input  wire logic                   bit_a_ok_i,
  input  wire logic                   bit_b_data_i,
  input  wire logic                   bit_b_ok_i,
  output logic                        bit_ready_o,
  input  wire logic [`RSE_ADDR_W-1:0] reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [`RSE_DATA_W-1:0] reg_wdata_i,
  output var  logic [`RSE_DATA_W-1:0] reg_rdata_o,
  output var  logic                   irq_o
);

  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else if (ce_i) begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // register decode
  wire sel_ctrl    = (reg_addr_i == `RSE_OFF_CTRL);
  wire sel_en      = (reg_addr_i == `RSE_OFF_EN);
  wire sel_stat    = (reg_addr_i == `RSE_OFF_STAT);
  wire sel_data_a  = (reg_addr_i == `RSE_OFF_DATA_A);
  wire sel_valid_a = (reg_addr_i == `RSE_OFF_VALID_A);
  wire sel_data_b  = (reg_addr_i == `RSE_OFF_DATA_B);
  wire sel_valid_b = (reg_addr_i == `RSE_OFF_VALID_B);
  wire stat_rd     = reg_rd_i & sel_stat;
  wire hold_rd_a   = reg_rd_i & sel_data_a;
  wire hold_rd_b   = reg_rd_i & sel_data_b;

  // software-written registers
  logic [`RSE_GAP_W-1:0]  gap_len;
  logic [`RSE_DATA_W-1:0] enable;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_len <= `RSE_RST_GAP;
      enable  <= `RSE_RST_BYTE;
    end else if (ce_i) begin
      if (reg_wr_i && sel_ctrl) begin
        gap_len <= reg_wdata_i[`RSE_GAP_MSB:`RSE_GAP_LSB];
      end
      if (reg_wr_i && sel_en) begin
        enable <= reg_wdata_i;
      end
    end
  end

  // bit FIFO: the drain pauses on a host read of status or a holding
  // register so that no byte lands on the same edge as that read
  logic [`RSE_FIFO_WIDTH-1:0] fifo_out;
  logic                       fifo_valid;
  wire                        drain_ready = ~(stat_rd | hold_rd_a | hold_rd_b);
  wire                        bit_stb     = fifo_valid & drain_ready;

  rse_fifo #(
    .WIDTH (`RSE_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .ce_i      (ce_i),
    .s_valid_i (bit_valid_i),
    .s_data_i  ({bit_b_ok_i, bit_b_data_i, bit_a_ok_i, bit_a_data_i}),
    .s_ready_o (bit_ready_o),
    .m_valid_o (fifo_valid),
    .m_data_o  (fifo_out),
    .m_ready_i (drain_ready)
  );

  // the two receive channels
  rse_byte_t data_a;
  rse_byte_t mask_a;
  rse_byte_t data_b;
  rse_byte_t mask_b;
  logic      load_a;
  logic      load_b;
  logic      allv_a;
  logic      allv_b;
  logic      ovf_a_ev;
  logic      ovf_b_ev;
  logic      unf_a_ev;
  logic      unf_b_ev;
  logic      eof_a_ev;
  logic      eof_b_ev;

  rse_chan #(
    .BYTE_W (`RSE_BYTE_W),
    .GAP_W  (`RSE_GAP_W)
  ) u_chan_a (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .rx_en_i     (rx_en_i),
    .gap_len_i   (gap_len),
    .bit_stb_i   (bit_stb),
    .bit_data_i  (fifo_out[0]),
    .bit_ok_i    (fifo_out[1]),
    .hold_rd_i   (hold_rd_a),
    .hold_data_o (data_a),
    .hold_mask_o (mask_a),
    .load_o      (load_a),
    .all_valid_o (allv_a),
    .ovf_o       (ovf_a_ev),
    .unf_o       (unf_a_ev),
    .eof_o       (eof_a_ev)
  );

  rse_chan #(
    .BYTE_W (`RSE_BYTE_W),
    .GAP_W  (`RSE_GAP_W)
  ) u_chan_b (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .rx_en_i     (rx_en_i),
    .gap_len_i   (gap_len),
    .bit_stb_i   (bit_stb),
    .bit_data_i  (fifo_out[2]),
    .bit_ok_i    (fifo_out[3]),
    .hold_rd_i   (hold_rd_b),
    .hold_data_o (data_b),
    .hold_mask_o (mask_b),
    .load_o      (load_b),
    .all_valid_o (allv_b),
    .ovf_o       (ovf_b_ev),
    .unf_o       (unf_b_ev),
    .eof_o       (eof_b_ev)
  );

  // pending flags: a new event wins over a clearing status read
  logic full_a;
  logic full_b;
  logic eof_a;
  logic eof_b;
  logic ovf_a;
  logic ovf_b;
  logic unf_a;
  logic unf_b;

  wire keep = ~stat_rd;
  wire next_full_a = rx_en_i & (load_a | (full_a & keep));
  wire next_full_b = rx_en_i & (load_b | (full_b & keep));
  wire next_eof_a  = rx_en_i & (eof_a_ev | (eof_a & keep));
  wire next_eof_b  = rx_en_i & (eof_b_ev | (eof_b & keep));
  wire next_ovf_a  = rx_en_i & (ovf_a_ev | (ovf_a & keep));
  wire next_ovf_b  = rx_en_i & (ovf_b_ev | (ovf_b & keep));
  wire next_unf_a  = rx_en_i & (unf_a_ev | (unf_a & keep));
  wire next_unf_b  = rx_en_i & (unf_b_ev | (unf_b & keep));

  // sources of the interrupt, laid out like the enable register
  logic [`RSE_DATA_W-1:0] next_src;

  always_comb begin
    next_src                = '0;
    next_src[`RSE_EN_UNF_B] = next_unf_b;
    next_src[`RSE_EN_OVF_B] = next_ovf_b;
    next_src[`RSE_EN_EOF_B] = next_eof_b;
    next_src[`RSE_EN_FULL_B] = next_full_b;
    next_src[`RSE_EN_UNF_A] = next_unf_a;
    next_src[`RSE_EN_OVF_A] = next_ovf_a;
    next_src[`RSE_EN_EOF_A] = next_eof_a;
    next_src[`RSE_EN_FULL_A] = next_full_a;
  end

  // the all-valid bits have no place among the sources
  wire next_irq = |(next_src & enable);

  // pending flags, all-valid bits and the interrupt line
  logic valid_a;
  logic valid_b;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      full_a  <= 1'b0;
      full_b  <= 1'b0;
      eof_a   <= 1'b0;
      eof_b   <= 1'b0;
      ovf_a   <= 1'b0;
      ovf_b   <= 1'b0;
      unf_a   <= 1'b0;
      unf_b   <= 1'b0;
      irq_o   <= 1'b0;
    end else if (ce_i) begin
      full_a  <= next_full_a;
      full_b  <= next_full_b;
      eof_a   <= next_eof_a;
      eof_b   <= next_eof_b;
      ovf_a   <= next_ovf_a;
      ovf_b   <= next_ovf_b;
      unf_a   <= next_unf_a;
      unf_b   <= next_unf_b;
      irq_o   <= next_irq;
    end
  end

  assign valid_a = allv_a;
  assign valid_b = allv_b;

  // status word, set regardless of enables and zero outside receive
  logic [`RSE_DATA_W-1:0] status;

  always_comb begin
    status                   = `RSE_RST_BYTE;
    status[`RSE_ST_VALID_B]  = valid_b;
    status[`RSE_ST_FLOW_B]   = ovf_b | unf_b;
    status[`RSE_ST_EOF_B]    = eof_b;
    status[`RSE_ST_FULL_B]   = full_b;
    status[`RSE_ST_VALID_A]  = valid_a;
    status[`RSE_ST_FLOW_A]   = ovf_a | unf_a;
    status[`RSE_ST_EOF_A]    = eof_a;
    status[`RSE_ST_FULL_A]   = full_a;
  end

  // read data selection, unmapped addresses read zero
  wire [`RSE_DATA_W-1:0] ctrl_word = {{(`RSE_DATA_W-`RSE_GAP_W){1'b0}}, gap_len};
  wire [`RSE_DATA_W-1:0] rd_mux =
    sel_ctrl    ? ctrl_word :
    sel_en      ? enable    :
    sel_stat    ? status    :
    sel_data_a  ? data_a    :
    sel_valid_a ? mask_a    :
    sel_data_b  ? data_b    :
    sel_valid_b ? mask_b    :
    `RSE_RST_BYTE;

  // read data is captured on the read strobe and held until the next read
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= `RSE_RST_BYTE;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// file: verif/rse_host.sv
/*
  Host model: one-cycle register read and write strobes.
  Assumes strobes launched off the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module rse_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [5:0] addr_o,
  output var  logic       rd_o,
  output var  logic       wr_o,
  output var  logic [7:0] wdata_o
);
  // idle bus
  initial begin
    addr_o  = 6'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // write strobe; address and data scrambled once released
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask

  // read strobe; data is settled one edge after it is taken
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    d      = rdata_i;
    rd_o   = 1'b0;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// file: verif/rse_top_props.sv
/*
  Port-level checker of the receive event logic.
  Assumes it sees only the top module's ports and is bound below.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rse_cfg.svh"

module rse_top_props (
  input wire logic                   core_clk_i,
  input wire logic                   rstn_i,
  input wire logic                   ce_i,
  input wire logic                   rx_en_i,
  input wire logic                   bit_ready_o,
  input wire logic [`RSE_ADDR_W-1:0] reg_addr_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [`RSE_DATA_W-1:0] reg_wdata_i,
  input wire logic [`RSE_DATA_W-1:0] reg_rdata_o,
  input wire logic                   irq_o
);
  logic [2:0] ctrl_sh;
  logic [7:0] en_sh;
  wire        rd_take = reg_rd_i && ce_i;
  wire        wr_take = reg_wr_i && ce_i;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // shadow copies of the two writable registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_sh <= 3'h0;
      en_sh   <= 8'h00;
    end else if (wr_take && reg_addr_i == 6'h06) begin
      ctrl_sh <= reg_wdata_i[2:0];
    end else if (wr_take && reg_addr_i == 6'h07) begin
      en_sh <= reg_wdata_i;
    end
  end

  property p_rst_quiet;
    disable iff (1'b0) !rstn_i ##1 !rstn_i |-> !irq_o && !bit_ready_o && reg_rdata_o == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet in reset");
  property p_rd_hold;
    !rd_take |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_unmapped;
    rd_take && (reg_addr_i < 6'h06 || reg_addr_i > 6'h0C) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_read;
    rd_take && reg_addr_i == 6'h06 |=> reg_rdata_o == {5'h00, ctrl_sh};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("gap field readback wrong");
  property p_en_read;
    rd_take && reg_addr_i == 6'h07 |=> reg_rdata_o == en_sh;
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable readback wrong");
  property p_off_status;
    !rx_en_i [*3] ##0 (rd_take && reg_addr_i == 6'h08) |=> reg_rdata_o == 8'h00;
  endproperty
  a_off_status: assert property (p_off_status) else $error("status not zero outside receive");
  property p_off_irq;
    !rx_en_i [*3] |-> !irq_o;
  endproperty
  a_off_irq: assert property (p_off_irq) else $error("interrupt outside receive");
  property p_no_en_irq;
    en_sh == 8'h00 [*2] |-> !irq_o;
  endproperty
  a_no_en_irq: assert property (p_no_en_irq) else $error("interrupt with all enables off");
  property p_ready_boot;
    $rose(rstn_i) |-> !bit_ready_o ##1 !bit_ready_o;
  endproperty
  a_ready_boot: assert property (p_ready_boot) else $error("bit queue ready too early");

  c_irq: cover property ($rose(irq_o));
  c_fill: cover property ($fell(bit_ready_o));
  c_stat: cover property (rd_take && reg_addr_i == 6'h08 ##1 reg_rdata_o != 8'h00);
endmodule

bind rse_top rse_top_props i_props (
  .core_clk_i  (core_clk_i),
  .rstn_i      (rstn_i),
  .ce_i        (ce_i),
  .rx_en_i     (rx_en_i),
  .bit_ready_o (bit_ready_o),
  .reg_addr_i  (reg_addr_i),
  .reg_wr_i    (reg_wr_i),
  .reg_rd_i    (reg_rd_i),
  .reg_wdata_i (reg_wdata_i),
  .reg_rdata_o (reg_rdata_o),
  .irq_o       (irq_o)
);
`default_nettype wire

// file: verif/test_rx_serdes_event_logic.sv
/*
  Self-checking bench of the receive event logic.
  Assumes the host model and the bound checker beside it.
*/
`timescale 1ns/100ps
`default_nettype none

module test_rx_serdes_event_logic;
  import rse_pkg::*;
  localparam int DEPTH = 4;
  logic      core_clk_i = 1'b0;
  logic      rstn_i = 1'b0;
  logic      rx_en_i = 1'b0;
  logic      bit_valid_i = 1'b0;
  logic      a_d = 1'b0, a_ok = 1'b0, b_d = 1'b0, b_ok = 1'b0;
  logic      bit_ready_o, reg_wr_i, reg_rd_i, irq_o, fill_on = 1'b0, saw_full = 1'b0;
  logic [5:0] reg_addr_i;
  rse_byte_t reg_wdata_i, reg_rdata_o, rd_val, exp_b;
  int        bad_count = 0, comparisons = 0, cycles = 0, seed = 32'h7704, i, g;

  always #12.5 core_clk_i = ~core_clk_i;

  rse_top #(.FIFO_DEPTH(DEPTH)) i_dut (
    .core_clk_i (core_clk_i), .rstn_i (rstn_i), .ce_i (1'b1), .rx_en_i (rx_en_i),
    .bit_valid_i (bit_valid_i), .bit_a_data_i (a_d), .bit_a_ok_i (a_ok),
    .bit_b_data_i (b_d), .bit_b_ok_i (b_ok), .bit_ready_o (bit_ready_o),
    .reg_addr_i (reg_addr_i), .reg_wr_i (reg_wr_i), .reg_rd_i (reg_rd_i),
    .reg_wdata_i (reg_wdata_i), .reg_rdata_o (reg_rdata_o), .irq_o (irq_o)
  );
  rse_host i_host (
    .clk_i (core_clk_i), .rdata_i (reg_rdata_o), .addr_o (reg_addr_i),
    .rd_o (reg_rd_i), .wr_o (reg_wr_i), .wdata_o (reg_wdata_i)
  );

  // cycle ceiling and queue-full watch
  always @(posedge core_clk_i) begin
    cycles++;
    if (fill_on && bit_ready_o === 1'b0) saw_full = 1'b1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic rse_byte_t stat(input logic vb, fb, eb, ub, va, fa, ea, ua);
    return {vb, fb, eb, ub, va, fa, ea, ua};
  endfunction

  task automatic chk(input rse_byte_t got, input rse_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] a, input rse_byte_t exp);
    i_host.rd_reg(a, rd_val);
    chk(rd_val, exp);
  endtask

  // offer one bit time, held until the queue takes it
  task automatic push(input logic ad, aok, bd, bok);
    int n;
    @(negedge core_clk_i);
    bit_valid_i = 1'b1;
    {a_d, a_ok, b_d, b_ok} = {ad, aok, bd, bok};
    @(posedge core_clk_i);
    for (n = 0; n < 200 && bit_ready_o !== 1'b1; n++) @(posedge core_clk_i);
  endtask

  // drop the offer, then look for the interrupt within a bounded time
  task automatic wait_irq(input logic exp);
    logic seen;
    int n;
    seen = 1'b0;
    for (n = 0; n < 16 && !(seen && exp); n++) begin
      @(negedge core_clk_i);
      bit_valid_i = 1'b0;
      seen = seen | (irq_o === 1'b1);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  // leave receive mode, status must read zero, then re-enter
  task automatic clean();
    @(negedge core_clk_i);
    bit_valid_i = 1'b0;
    rx_en_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    rd_chk(6'h08, 8'h00);
    rx_en_i = 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    rx_en_i = 1'b1;
    // reset values, unmapped and read-only places
    rd_chk(6'h06, 8'h00);
    rd_chk(6'h08, 8'h00);
    rd_chk(6'h3F, 8'h00);
    i_host.wr_reg(6'h08, 8'hFF);
    rd_chk(6'h08, 8'h00);
    exp_b = 8'($random(seed));
    i_host.wr_reg(6'h07, exp_b);
    rd_chk(6'h07, exp_b);
    i_host.wr_reg(6'h06, ~exp_b);
    rd_chk(6'h06, {5'h00, ~exp_b[2:0]});
    // whole byte on channel A, then a second one left pending
    i_host.wr_reg(6'h07, 8'h01);
    exp_b = 8'($random(seed));
    for (i = 0; i < 8; i++) push(exp_b[i], 1'b1, 1'b0, 1'b0);
    wait_irq(1'b1);
    rd_chk(6'h08, stat(0, 0, 0, 0, 1, 0, 0, 1));
    chk({7'h00, irq_o}, 8'h00);
    rd_chk(6'h09, exp_b);
    rd_chk(6'h0A, 8'hFF);
    for (i = 0; i < 8; i++) push(1'($random(seed)), 1'b1, 1'b0, 1'b0);
    wait_irq(1'b1);
    // end of frame on both channels at the gap boundaries
    for (g = 0; g < 8; g += 7) begin
      clean();
      i_host.wr_reg(6'h06, 8'(g));
      i_host.wr_reg(6'h07, 8'h22);
      push(1'b1, 1'b1, 1'b1, 1'b1);
      for (i = 0; i < g; i++) push(1'b0, 1'b0, 1'b0, 1'b0);
      wait_irq(1'b0);
      push(1'b0, 1'b0, 1'b0, 1'b0);
      wait_irq(1'b1);
      rd_chk(6'h08, stat(0, 0, 1, 1, 0, 0, 1, 1));
      chk({7'h00, irq_o}, 8'h00);
      rd_chk(6'h0A, 8'h01);
    end
    // underflow then overflow on holding register A
    clean();
    i_host.wr_reg(6'h07, 8'h08);
    i_host.rd_reg(6'h09, rd_val);
    wait_irq(1'b1);
    rd_chk(6'h08, stat(0, 0, 0, 0, 0, 1, 0, 0));
    i_host.wr_reg(6'h07, 8'h04);
    for (i = 0; i < 16; i++) push(1'($random(seed)), 1'b1, 1'b0, 1'b0);
    wait_irq(1'b1);
    rd_chk(6'h08, stat(0, 0, 0, 0, 1, 1, 0, 1));
    // channel B: partial and whole valid masks, underflow, polling
    for (g = 0; g < 2; g++) begin
      clean();
      i_host.wr_reg(6'h06, 8'h07);
      i_host.wr_reg(6'h07, 8'hF0);
      exp_b = (g == 1) ? 8'hFF : ((8'($random(seed)) & 8'h7F) | 8'h01);
      for (i = 0; i < 8; i++) push(1'b0, 1'b0, 1'($random(seed)), exp_b[i]);
      wait_irq(1'b1);
      rd_chk(6'h08, stat(&exp_b, 0, 0, 1, 0, 0, 0, 0));
      rd_chk(6'h0C, exp_b);
      i_host.rd_reg(6'h0B, rd_val);
      i_host.rd_reg(6'h0B, rd_val);
      wait_irq(1'b1);
      rd_chk(6'h08, stat(&exp_b, 1, 0, 0, 0, 0, 0, 0));
      rd_chk(6'h08, stat(&exp_b, 0, 0, 0, 0, 0, 0, 0));
      chk({7'h00, irq_o}, 8'h00);
    end
    // stall the drain with status reads until the bit queue refuses
    clean();
    fill_on = 1'b1;
    fork
      for (i = 0; i < 4 * DEPTH; i++) push(1'($random(seed)), 1'b0, 1'b0, 1'b0);
      for (g = 0; g < 4 * DEPTH; g++) i_host.rd_reg(6'h08, rd_val);
    join
    fill_on = 1'b0;
    chk({7'h00, saw_full}, 8'h01);
    wait_irq(1'b0);
    chk({7'h00, bit_ready_o}, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
